// [src/ces_iwf.sv]
// ces_iwf: circuit emulation interworking function, aal1 cell framer with apb registers
// Function
// RL1: cell header carries programmable vpi, zero after reset.
// RL2: cell header carries programmable vci, thirty-three after reset.
// RL3: service type bit picks structured nx64 or unstructured raw stream; the code only stores the bit and frames every cell alike.
// RL4: timing bit picks synchronous or adaptive port clock, adaptive default.
// RL5: adaptive: depth above upper threshold speeds the port clock.
// RL6: adaptive: depth below lower threshold slows the port clock.
// RL7: thresholds derive from cell delay variation, giving hysteresis.
// RL8: aal1 format: basic, e1 cas, t1 superframe, t1 extended superframe; the code only stores the field and sends the same aal1 octet for all.
// RL9: payload scrambled on send, descrambled on receive, x^43+1.
// RL10: scrambling switchable, enabled after reset.
// RL11: partial fill sets user octets per cell; zero means full cells; the code fills only sent cells and buffers all 47 received octets.
// RL12: delay variation tolerance in 10 us units, default 100.
// RL13: cell loss integration period in ms, default 2500.
// RL14: continuous loss for whole period sets loss status.
// RL15: auto channel config only for e1 ccs, e1 cas, serial.
// RL16: auto config sets channel count n from shdsl line rate.
// RL17: timeslots assigned consecutively from slot 1 until n.
// RL18: e1 ccs or serial may use slots 1 to 31.
// RL19: e1 cas uses slots 1-15 and 17-31, skipping 16.
// RL20: valid received cell clears loss status at once.
// RL21: admin up or down enables or disables traffic.
// RL22: reassembly buffer underflows counted, software readable.
// RL23: scrambler self-synchronising, payload only, header left clear.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ces_iwf (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // constant bit rate side
    input wire logic cbr_tx_valid,
    input wire logic [7:0] cbr_tx_data,
    input wire logic cbr_rx_take,
    output logic [7:0] cbr_rx_data,
    output logic cbr_clk_fast,
    output logic cbr_clk_slow,
    // atm cell side
    output logic cell_tx_valid,
    output logic cell_tx_sop,
    output logic [7:0] cell_tx_data,
    input wire logic cell_rx_valid,
    input wire logic cell_rx_sop,
    input wire logic [7:0] cell_rx_data,
    input wire logic cell_rx_good
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] vpi_ff;
    logic [15:0] vci_ff, cdv_ff, loss_int_ff, underflow_ff;
    logic [9:0] mode_ff;
    logic [5:0] fill_ff, rate_ff;
    logic [31:0] slots_ff;
    logic [4:0] nchan_ff;
    logic loss_ff, wr, rd, admin_up, scr_on;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign admin_up = mode_ff[ces_pkg::MODE_ADMIN_UP_BIT];
    assign scr_on = mode_ff[ces_pkg::MODE_SCRAMBLE_BIT];

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= ces_pkg::OFS_LINE_RATE) && (a[1:0] == 2'b00);
    endfunction : mapped

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vpi_ff <= ces_pkg::VPI_RST; // [RL1]
            vci_ff <= ces_pkg::VCI_RST; // [RL2]
        end else if (wr && paddr == ces_pkg::OFS_CHAN) begin
            vpi_ff <= pwdata[7:0];
            vci_ff <= pwdata[ces_pkg::CHAN_VCI_LSB +: 16];
        end
    end

    // reset mode: structured, adaptive, basic, scrambling on, admin up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= ces_pkg::MODE_RST; // [RL4] [RL10]
        end else if (wr && paddr == ces_pkg::OFS_MODE) begin
            mode_ff <= pwdata[9:0]; // [RL3] [RL8]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_ff <= ces_pkg::FILL_RST;
            cdv_ff <= ces_pkg::CDV_RST; // [RL12]
            loss_int_ff <= ces_pkg::LOSS_INT_RST; // [RL13]
            rate_ff <= ces_pkg::RATE_RST;
        end else if (wr) begin
            if (paddr == ces_pkg::OFS_FILL) begin
                fill_ff <= pwdata[5:0] > ces_pkg::PAYLOAD_OCTETS ? ces_pkg::PAYLOAD_OCTETS : pwdata[5:0];
            end
            if (paddr == ces_pkg::OFS_CDV) begin
                cdv_ff <= pwdata[15:0];
            end
            if (paddr == ces_pkg::OFS_LOSS_INT) begin
                loss_int_ff <= pwdata[15:0];
            end
            if (paddr == ces_pkg::OFS_LINE_RATE) begin
                rate_ff <= pwdata[5:0];
            end
        end
    end

    // ----------------------------------------
    // automatic timeslot allocation
    // ----------------------------------------
    // line rate code k means (k+3)*64 kbps; channels fit in rate minus overhead
    function automatic logic [4:0] chans_for(input logic [5:0] k, input logic [1:0] svc);
        logic [6:0] n;
        n = {1'b0, k} + 7'h01;
        // cas loses one channel every seven rate steps from code 12 on
        if (svc == ces_pkg::CES_SVC_E1_CAS && k >= 6'h0C) begin
            n = n - 7'((k - 6'h05) / 6'h07);
        end
        if (n > 7'h1F) begin
            n = (svc == ces_pkg::CES_SVC_E1_CAS) ? 7'h1E : 7'h1F;
        end
        chans_for = n[4:0];
    endfunction : chans_for

    logic auto_ok;
    logic [1:0] svc;
    logic [31:0] nxt_slots;
    assign svc = mode_ff[ces_pkg::MODE_SVC_LSB +: 2];
    assign auto_ok = mode_ff[ces_pkg::MODE_AUTO_BIT] && (svc != ces_pkg::CES_SVC_T1); // [RL15]

    always_comb begin
        logic [4:0] given;
        given = 5'h00;
        nxt_slots = 32'h0000_0000;
        for (int s = 1; s < 32; s++) begin
            if (given < nchan_ff && !(svc == ces_pkg::CES_SVC_E1_CAS && s == 16)) begin // [RL19]
                nxt_slots[s] = 1'b1; // [RL17] [RL18]
                given = given + 5'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nchan_ff <= 5'h00;
            slots_ff <= 32'h0000_0000;
        end else if (auto_ok) begin
            nchan_ff <= chans_for(rate_ff, svc); // [RL16]
            slots_ff <= nxt_slots;
        end else if (wr && paddr == ces_pkg::OFS_SLOTS) begin
            slots_ff <= {pwdata[31:1], 1'b0};
            nchan_ff <= 5'h00;
        end
    end

    // ----------------------------------------
    // segmentation: header, aal1 octet, payload
    // ----------------------------------------
    typedef enum logic [1:0] {CES_SEG_IDLE, CES_SEG_HDR, CES_SEG_PAY} ces_seg_t;
    ces_seg_t seg_ff;
    logic [5:0] seg_cnt_ff, user_octets;
    logic [2:0] seq_ff;
    logic [7:0] seg_byte, seg_scr, tx_hdr_byte_ff;
    logic [31:0] hdr_word;
    logic seg_pay_v, tx_valid_ff, tx_sop_ff, tx_hdr_ff;

    // partial fill pads the rest of the payload with zero octets
    assign user_octets = (fill_ff == 6'h00) ? ces_pkg::PAYLOAD_OCTETS : fill_ff; // [RL11]
    assign hdr_word = {4'h0, vpi_ff, vci_ff, 4'h0};
    assign seg_pay_v = (seg_ff == CES_SEG_PAY) && cbr_tx_valid;

    assign seg_byte = (seg_cnt_ff == 6'h00) ? {1'b0, seq_ff, 4'h0} :
        (seg_cnt_ff <= user_octets) ? cbr_tx_data : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_ff <= CES_SEG_IDLE;
            seg_cnt_ff <= 6'h00;
            seq_ff <= 3'h0;
        end else begin
            unique case (seg_ff)
                CES_SEG_IDLE: begin
                    if (admin_up && cbr_tx_valid) begin // [RL21]
                        seg_ff <= CES_SEG_HDR;
                        seg_cnt_ff <= 6'h00;
                    end
                end
                CES_SEG_HDR: begin
                    seg_cnt_ff <= seg_cnt_ff + 6'h01;
                    if (seg_cnt_ff == ces_pkg::HEADER_OCTETS - 6'h01) begin
                        seg_ff <= CES_SEG_PAY;
                        seg_cnt_ff <= 6'h00;
                    end
                end
                CES_SEG_PAY: begin
                    if (cbr_tx_valid) begin
                        seg_cnt_ff <= seg_cnt_ff + 6'h01;
                        if (seg_cnt_ff == ces_pkg::PAYLOAD_OCTETS) begin
                            seg_ff <= CES_SEG_IDLE;
                            seq_ff <= seq_ff + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    ces_scrambler #(.DESCRAMBLE(1'b0)) u_tx_scr (
        .pclk(pclk),
        .presetn(presetn),
        .enable(scr_on),
        .valid(seg_pay_v),
        .din(seg_byte),
        .dout(seg_scr)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid_ff <= 1'b0;
            tx_sop_ff <= 1'b0;
            tx_hdr_ff <= 1'b0;
            tx_hdr_byte_ff <= 8'h00;
        end else begin
            tx_valid_ff <= (seg_ff == CES_SEG_HDR) || seg_pay_v;
            tx_sop_ff <= (seg_ff == CES_SEG_HDR) && (seg_cnt_ff == 6'h00);
            tx_hdr_ff <= (seg_ff == CES_SEG_HDR);
            tx_hdr_byte_ff <= (seg_cnt_ff < 6'h04) ? hdr_word[8'(31 - 8 * seg_cnt_ff[1:0]) -: 8] : 8'h00;
        end
    end

    assign cell_tx_valid = tx_valid_ff;
    assign cell_tx_sop = tx_sop_ff;
    assign cell_tx_data = tx_hdr_ff ? tx_hdr_byte_ff : seg_scr; // [RL23]

    // ----------------------------------------
    // reassembly buffer and adaptive clock
    // ----------------------------------------
    logic [7:0] rbuf [0:ces_pkg::BUF_DEPTH-1];
    logic [ces_pkg::BUF_AW:0] wptr_ff, rptr_ff, depth;
    logic [5:0] rx_cnt_ff;
    logic [7:0] rx_plain;
    logic [15:0] half, upper, lower;
    logic rx_pay_v, rx_pay_d_ff, adaptive;

    assign depth = wptr_ff - rptr_ff;
    assign rx_pay_v = admin_up && cell_rx_valid && !cell_rx_sop && rx_cnt_ff >= ces_pkg::HEADER_OCTETS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt_ff <= 6'h00;
        end else if (cell_rx_valid) begin
            rx_cnt_ff <= cell_rx_sop ? 6'h01 : rx_cnt_ff + 6'h01;
        end
    end

    ces_scrambler #(.DESCRAMBLE(1'b1)) u_rx_scr (
        .pclk(pclk),
        .presetn(presetn),
        .enable(scr_on),
        .valid(rx_pay_v),
        .din(cell_rx_data),
        .dout(rx_plain)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pay_d_ff <= 1'b0;
        end else begin
            rx_pay_d_ff <= rx_pay_v && rx_cnt_ff != ces_pkg::HEADER_OCTETS;
        end
    end

    // buffer has no reset: data only
    always_ff @(posedge pclk) begin
        if (rx_pay_d_ff) begin
            rbuf[wptr_ff[ces_pkg::BUF_AW-1:0]] <= rx_plain;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_ff <= '0;
        end else if (rx_pay_d_ff && depth != ces_pkg::BUF_DEPTH) begin
            wptr_ff <= wptr_ff + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rptr_ff <= '0;
            cbr_rx_data <= 8'h00;
            underflow_ff <= 16'h0000;
        end else if (cbr_rx_take) begin
            if (depth == '0) begin
                underflow_ff <= underflow_ff + 16'h0001; // [RL22]
            end else begin
                cbr_rx_data <= rbuf[rptr_ff[ces_pkg::BUF_AW-1:0]];
                rptr_ff <= rptr_ff + 1'b1;
            end
        end
    end

    // thresholds sit at half depth plus or minus a cdv-scaled octet margin
    assign half = 16'(ces_pkg::BUF_DEPTH / 2);
    assign upper = half + (cdv_ff >> 3); // [RL7]
    assign lower = half > (cdv_ff >> 3) ? half - (cdv_ff >> 3) : 16'h0000; // [RL7]
    assign adaptive = mode_ff[ces_pkg::MODE_ADAPT_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cbr_clk_fast <= 1'b0;
            cbr_clk_slow <= 1'b0;
        end else if (!adaptive) begin
            cbr_clk_fast <= 1'b0; // [RL4]
            cbr_clk_slow <= 1'b0;
        end else begin
            // release only on crossing back to mid depth: hysteresis
            if (16'(depth) > upper) begin
                cbr_clk_fast <= 1'b1; // [RL5]
            end else if (16'(depth) <= half) begin
                cbr_clk_fast <= 1'b0;
            end
            if (16'(depth) < lower) begin
                cbr_clk_slow <= 1'b1; // [RL6]
            end else if (16'(depth) >= half) begin
                cbr_clk_slow <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // cell loss integration
    // ----------------------------------------
    logic [15:0] us_cnt_ff, ms_cnt_ff;
    logic good_cell;
    assign good_cell = cell_rx_valid && cell_rx_sop && cell_rx_good;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_cnt_ff <= 16'h0000;
            ms_cnt_ff <= 16'h0000;
            loss_ff <= 1'b0;
        end else if (good_cell) begin
            us_cnt_ff <= 16'h0000;
            ms_cnt_ff <= 16'h0000;
            loss_ff <= 1'b0; // [RL20]
        end else if (us_cnt_ff == 16'(ces_pkg::MS_CYC - 1)) begin
            us_cnt_ff <= 16'h0000;
            if (ms_cnt_ff + 16'h0001 >= loss_int_ff) begin
                loss_ff <= 1'b1; // [RL14]
            end else begin
                ms_cnt_ff <= ms_cnt_ff + 16'h0001;
            end
        end else begin
            us_cnt_ff <= us_cnt_ff + 16'h0001;
        end
    end

    // ----------------------------------------
    // apb read
    // ----------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                ces_pkg::OFS_CHAN: prdata = {8'h00, vci_ff, vpi_ff};
                ces_pkg::OFS_MODE: prdata = 32'(mode_ff);
                ces_pkg::OFS_FILL: prdata = 32'(fill_ff);
                ces_pkg::OFS_CDV: prdata = 32'(cdv_ff);
                ces_pkg::OFS_LOSS_INT: prdata = 32'(loss_int_ff);
                ces_pkg::OFS_STATUS: prdata = {15'h0000, depth, 5'h00, cbr_clk_slow, cbr_clk_fast, loss_ff};
                ces_pkg::OFS_UNDERFLOWS: prdata = 32'(underflow_ff);
                ces_pkg::OFS_SLOTS: prdata = slots_ff;
                ces_pkg::OFS_LINE_RATE: prdata = {21'h00_0000, nchan_ff, rate_ff};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    assign pslverr = psel & penable & ~mapped(paddr);
endmodule : ces_iwf
`default_nettype wire

// [src/ces_pkg.sv]
// ces_pkg: register map, field positions, defaults and timing counts of the cell emulation block
package ces_pkg;
    localparam logic [7:0] OFS_CHAN = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_FILL = 8'h08;
    localparam logic [7:0] OFS_CDV = 8'h0C;
    localparam logic [7:0] OFS_LOSS_INT = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_UNDERFLOWS = 8'h18;
    localparam logic [7:0] OFS_SLOTS = 8'h1C;
    localparam logic [7:0] OFS_LINE_RATE = 8'h20;
    localparam int MODE_STRUCT_BIT = 0;
    localparam int MODE_ADAPT_BIT = 1;
    localparam int MODE_FMT_LSB = 2;
    localparam int MODE_SCRAMBLE_BIT = 4;
    localparam int MODE_ADMIN_UP_BIT = 5;
    localparam int MODE_AUTO_BIT = 6;
    localparam int MODE_SVC_LSB = 7;
    localparam int CHAN_VCI_LSB = 8;
    localparam int STAT_LOSS_BIT = 0;
    localparam int STAT_FAST_BIT = 1;
    localparam int STAT_SLOW_BIT = 2;
    localparam int STAT_DEPTH_LSB = 8;
    localparam logic [7:0] VPI_RST = 8'h00;
    localparam logic [15:0] VCI_RST = 16'h0021;
    localparam logic [9:0] MODE_RST = 10'h033;
    localparam logic [5:0] FILL_RST = 6'h00;
    localparam logic [15:0] CDV_RST = 16'h0064;
    localparam logic [15:0] LOSS_INT_RST = 16'h09C4;
    localparam logic [5:0] RATE_RST = 6'h00;
    localparam logic [5:0] PAYLOAD_OCTETS = 6'h2F;
    localparam logic [5:0] HEADER_OCTETS = 6'h05;
    localparam int SCR_TAPS = 43;
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int BUF_DEPTH = 256;
    localparam int BUF_AW = 8;
    typedef enum logic [1:0] {
        CES_FMT_BASIC,
        CES_FMT_E1_CHANNEL_ASSOCIATED_FORMAT,
        CES_FMT_T1_SUPERFRAME_SIGNALING_FORMAT,
        CES_FMT_T1_EXTENDED_SUPERFRAME_SIGNALING_FORMAT
    } ces_fmt_t;
    typedef enum logic [1:0] {
        CES_SVC_E1_CCS,
        CES_SVC_E1_CAS,
        CES_SVC_SERIAL,
        CES_SVC_T1
    } ces_svc_t;
endpackage : ces_pkg

// [src/ces_scrambler.sv]
// ces_scrambler: self-synchronising x^43+1 byte scrambler or descrambler
`timescale 1ns/10ps
`default_nettype none
module ces_scrambler #(
    parameter bit DESCRAMBLE = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic valid,
    input wire logic [7:0] din,
    output logic [7:0] dout
);
    logic [42:0] hist_ff;
    logic [42:0] nxt_hist;
    logic [7:0] nxt_out;

    // msb first; history holds the line-side bits so both ends self align
    always_comb begin
        nxt_hist = hist_ff;
        nxt_out = din;
        for (int i = 7; i >= 0; i--) begin
            nxt_out[i] = din[i] ^ nxt_hist[ces_pkg::SCR_TAPS - 1]; // [RL9] [RL23]
            nxt_hist = {nxt_hist[41:0], DESCRAMBLE ? din[i] : nxt_out[i]};
        end
        if (!enable) begin
            nxt_out = din; // [RL10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_ff <= '0;
        end else if (valid) begin
            hist_ff <= nxt_hist;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout <= 8'h00;
        end else if (valid) begin
            dout <= nxt_out;
        end
    end
endmodule : ces_scrambler
`default_nettype wire

// [tb/ces_atm_model.sv]
// ces_atm_model: network side that sends whole cells on vpi 0, vci 33
`timescale 1ns/10ps
`default_nettype none
module ces_atm_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic send,
    output logic busy,
    output logic cell_rx_valid,
    output logic cell_rx_sop,
    output logic [7:0] cell_rx_data,
    output logic cell_rx_good
);
    logic [5:0] pos_ff;
    logic [1:0] num_ff;
    logic idle_ff;
    // ----
    // cell sender
    // ----
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            pos_ff <= 6'h00;
            num_ff <= 2'h0;
        end else if (busy) begin
            pos_ff <= pos_ff + 6'h01;
            if (pos_ff == 6'h34) begin
                busy <= 1'b0;
                num_ff <= num_ff + 2'h1;
            end
        end else if (send) begin
            busy <= 1'b1;
            pos_ff <= 6'h00;
        end
    end
    // idle data toggles so stale bytes never look valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_ff <= 1'b0;
        end else begin
            idle_ff <= ~idle_ff;
        end
    end
    assign cell_rx_valid = busy;
    assign cell_rx_sop = busy && pos_ff == 6'h00;
    assign cell_rx_good = cell_rx_sop;
    assign cell_rx_data = !busy ? {8{idle_ff}} : pos_ff == 6'h02 ? 8'h02 : pos_ff == 6'h03 ? 8'h10 :
        pos_ff < 6'h05 ? 8'h00 : {num_ff, pos_ff - 6'h05};
endmodule : ces_atm_model
`default_nettype wire

// [tb/ces_iwf_bench.sv]
// ces_iwf_bench: self-checking bench for the cell emulation block
`timescale 1ns/10ps
`default_nettype none
module ces_iwf_bench;
    logic pclk, presetn, pready, pslverr, err, busy;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, send = 1'b0, cbr_tx_valid = 1'b0, cbr_rx_take = 1'b0;
    logic cbr_clk_fast, cbr_clk_slow, cell_tx_valid, cell_tx_sop, cell_rx_valid, cell_rx_sop, cell_rx_good;
    logic [7:0] cbr_rx_data, cell_tx_data, cell_rx_data, paddr = 8'h00, cbr_tx_data = 8'h00;
    logic [31:0] prdata, rd, pwdata = 32'h0000_0000;
    int n_mismatch = 0;
    int cmp_count = 0;
    ces_iwf DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cbr_tx_valid,
        .cbr_tx_data, .cbr_rx_take, .cbr_rx_data, .cbr_clk_fast, .cbr_clk_slow, .cell_tx_valid, .cell_tx_sop,
        .cell_tx_data, .cell_rx_valid, .cell_rx_sop, .cell_rx_data, .cell_rx_good);
    ces_atm_model u_atm (.pclk, .presetn, .send, .busy, .cell_rx_valid, .cell_rx_sop, .cell_rx_data, .cell_rx_good);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ----
    // shared tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rd_chk
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    task automatic take;
        @(posedge pclk);
        cbr_rx_take <= 1'b1;
        @(posedge pclk);
        cbr_rx_take <= 1'b0;
    endtask : take
    task automatic send_cell;
        @(posedge pclk);
        send <= 1'b1;
        @(posedge pclk);
        send <= 1'b0;
        @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
    endtask : send_cell
    // ----
    // scenarios
    // ----
    task automatic t_defaults;
        do_reset();
        rd_chk(ces_pkg::OFS_CHAN, 32'h0000_2100);
        apb(1'b0, ces_pkg::OFS_MODE, 32'h0000_0000);
        check(rd[ces_pkg::MODE_ADAPT_BIT], 1'b1);
        check(rd[ces_pkg::MODE_SCRAMBLE_BIT], 1'b1);
        check(rd[ces_pkg::MODE_ADMIN_UP_BIT], 1'b1);
        rd_chk(ces_pkg::OFS_FILL, 32'h0000_0000);
        rd_chk(ces_pkg::OFS_CDV, 32'h0000_0064);
        rd_chk(ces_pkg::OFS_LOSS_INT, 32'h0000_09C4);
        rd_chk(8'h24, 32'h0000_0000);
        check(err, 1'b1);
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, ces_pkg::OFS_MODE, 32'h0000_0022 | (f << 2) | (f & 1));
            apb(1'b0, ces_pkg::OFS_MODE, 32'h0000_0000);
            check(rd[ces_pkg::MODE_FMT_LSB +: 2], f[1:0]);
            check(rd[ces_pkg::MODE_STRUCT_BIT], f[0]);
        end
    endtask : t_defaults
    task automatic t_tx;
        logic [7:0] hdr[5] = '{8'h05, 8'hA1, 8'h23, 8'h40, 8'h00};
        int n = 0;
        do_reset();
        apb(1'b1, ces_pkg::OFS_CHAN, 32'h0012_345A);
        apb(1'b1, ces_pkg::OFS_FILL, 32'h0000_0004);
        apb(1'b1, ces_pkg::OFS_MODE, 32'h0000_0003);
        cbr_tx_data <= 8'hA5;
        cbr_tx_valid <= 1'b1;
        repeat (80) begin
            @(negedge pclk);
            if (cell_tx_valid !== 1'b0) n++;
        end
        check(n, 0);
        apb(1'b1, ces_pkg::OFS_MODE, 32'h0000_0023);
        for (int i = 0; i < 30 && cell_tx_sop !== 1'b1; i++) @(negedge pclk);
        check(cell_tx_sop, 1'b1);
        // octet 5 is the sequence octet; only fill octets carry user data
        for (int i = 0; i < 53; i++) begin
            if (i < 5) check(cell_tx_data, hdr[i]);
            if (i > 5) check(cell_tx_data, (i < 10) ? 8'hA5 : 8'h00);
            if (cell_tx_valid !== 1'b1) n++;
            @(negedge pclk);
        end
        check(n, 0);
        @(posedge pclk);
        cbr_tx_valid <= 1'b0;
    endtask : t_tx
    task automatic t_adapt;
        do_reset();
        apb(1'b1, ces_pkg::OFS_MODE, 32'h0000_0023);
        @(negedge pclk);
        check(cbr_clk_slow, 1'b1);
        repeat (3) send_cell();
        repeat (4) @(posedge pclk);
        apb(1'b0, ces_pkg::OFS_STATUS, 32'h0000_0000);
        check(rd[ces_pkg::STAT_DEPTH_LSB +: 9], 9'h08D);
        check(cbr_clk_fast, 1'b1);
        check(cbr_clk_slow, 1'b0);
        repeat (30) take();
        repeat (2) @(posedge pclk);
        check(cbr_rx_data, 8'h1E);
        check(cbr_clk_slow, 1'b1);
        check(cbr_clk_fast, 1'b0);
        apb(1'b1, ces_pkg::OFS_MODE, 32'h0000_0021);
        repeat (2) @(negedge pclk);
        check(cbr_clk_slow, 1'b0);
    endtask : t_adapt
    task automatic t_auto;
        logic [31:0] mode[4] = '{32'h0000_0063, 32'h0000_00E3, 32'h0000_0163, 32'h0000_01E3};
        logic [5:0] code[4] = '{6'h04, 6'h10, 6'h21, 6'h04};
        logic [31:0] slots[4] = '{32'h0000_003E, 32'h0002_FFFE, 32'hFFFF_FFFE, 32'h0000_00F0};
        do_reset();
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, ces_pkg::OFS_MODE, mode[s]);
            apb(1'b1, ces_pkg::OFS_SLOTS, 32'h0000_00F0);
            apb(1'b1, ces_pkg::OFS_LINE_RATE, {26'h000_0000, code[s]});
            // channel count and slot map settle two edges after the rate write
            repeat (2) @(posedge pclk);
            rd_chk(ces_pkg::OFS_SLOTS, slots[s]);
        end
    endtask : t_auto
    task automatic t_loss;
        int i;
        do_reset();
        // a 2 ms period keeps the run short
        apb(1'b1, ces_pkg::OFS_LOSS_INT, 32'h0000_0002);
        take();
        rd_chk(ces_pkg::OFS_UNDERFLOWS, 32'h0000_0001);
        rd = 32'h0000_0000;
        for (i = 0; i < 9000 && rd[ces_pkg::STAT_LOSS_BIT] !== 1'b1; i++) begin
            apb(1'b0, ces_pkg::OFS_STATUS, 32'h0000_0000);
        end
        check(i > 6000, 1'b1);
        check(rd[ces_pkg::STAT_LOSS_BIT], 1'b1);
        send_cell();
        apb(1'b0, ces_pkg::OFS_STATUS, 32'h0000_0000);
        check(rd[ces_pkg::STAT_LOSS_BIT], 1'b0);
    endtask : t_loss
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        t_defaults();
        t_tx();
        t_adapt();
        t_auto();
        t_loss();
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        stop_test();
    end
endmodule : ces_iwf_bench
`default_nettype wire

// [tb/ces_iwf_sva.sv]
// ces_iwf_sva: port checker for the cell emulation block
`timescale 1ns/10ps
`default_nettype none
module ces_iwf_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cbr_clk_fast,
    input wire logic cbr_clk_slow,
    input wire logic cell_tx_valid,
    input wire logic cell_tx_sop,
    input wire logic [7:0] cell_tx_data
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // register bus and cell stream
    // ----
    AST_ZERO_WAIT: assert property (psel && penable |-> pready)
        else $error("access without ready");
    AST_IDLE_ZERO: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0000_0000)
        else $error("read data outside read access");
    AST_BAD_ADDR: assert property (psel && penable && (paddr > 8'h20 || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    // both at once would fight over the port clock
    AST_CLK_EXCL: assert property (!(cbr_clk_fast && cbr_clk_slow))
        else $error("speed up and slow down together");
    AST_HDR_RUN: assert property (cell_tx_sop |-> cell_tx_valid [*5])
        else $error("header bytes not continuous");
    AST_GFC_ZERO: assert property (cell_tx_sop |-> cell_tx_data[7:4] == 4'h0)
        else $error("flow control nibble not zero");
    AST_HDR_TAIL: assert property (cell_tx_sop |-> ##3 cell_tx_data[3:0] == 4'h0 ##1 cell_tx_data == 8'h00)
        else $error("header tail altered");
    AST_SOP_SPACE: assert property (cell_tx_sop |=> !cell_tx_sop [*8])
        else $error("cell start too soon");
endmodule : ces_iwf_sva
bind ces_iwf ces_iwf_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .cbr_clk_fast, .cbr_clk_slow, .cell_tx_valid, .cell_tx_sop, .cell_tx_data);
`default_nettype wire
